//--- core/stabilization_time_counter.v
// Time base counter that measures the oscillator stabilization period
`timescale 1ns/1ps
module stabilization_time_counter (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       start,
  input  wire       osc_tick,
  input  wire       stabilization_clock_select,
  output reg        done
);
`include "stop_wake_map.vh"

  reg  [`STAB_WIDTH-1:0] count_reg;
  reg                    run_reg;
  wire [`STAB_WIDTH-1:0] last_count;

  // Terminal count is the selected power of two minus one
  assign last_count = stabilization_clock_select ?
                      ((10'h001 << `STAB_EXP_SEL1) - 10'h001) :
                      ((10'h001 << `STAB_EXP_SEL0) - 10'h001);

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_reg <= 10'h000;
      run_reg   <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count_reg <= 10'h000;
        run_reg   <= 1'b1;
      end else if (run_reg && osc_tick) begin
        if (count_reg == last_count) begin
          run_reg <= 1'b0;
          done    <= 1'b1;
        end else begin
          count_reg <= count_reg + 10'h001;
        end
      end
    end
  end

endmodule // stabilization_time_counter

//--- core/stop_wake_map.vh
// Constants for the STOP wake-up and clock output control block
`ifndef STOP_WAKE_MAP_VH
`define STOP_WAKE_MAP_VH

// Register offsets (plain port, word addresses)
`define ADDR_POWER_SAVE  4'h0
`define ADDR_STATUS      4'h1

// Power-save control field positions
`define PWR_INH_A_BIT    0
`define PWR_INH_B_BIT    1
`define PWR_STAB_SEL_BIT 2
`define PWR_EXT_CLK_BIT  3
`define PWR_STOP_BIT     4
`define PWR_WIDTH        5
`define PWR_RESET        5'h00

// Status field positions
`define ST_STOPPED_BIT   0
`define ST_WAIT_INACT    1
`define ST_COUNTING      2
`define ST_NMI_PEND      3
`define ST_IN_NMI        4
`define ST_WIDTH         5

// Time base divider exponents for select bit 0 and 1
`define STAB_EXP_SEL0    8
`define STAB_EXP_SEL1    9
`define STAB_WIDTH       10

`endif

//--- core/stop_wake_osc_stabilizer.v
// STOP mode wake-up, oscillator stabilization and clock output gating
// What this block does
// - Reset pin wake-up is a system reset plus a wake marker that gates the reset vector request.
// - Both inhibit bits set stop driving the clock output pin.
// - Flash programming mode keeps the clock output pin undriven.
// - Valid interrupt pin edge ends STOP.
// - After interrupt wake-up, counting starts at the pin's inactive edge.
// - Delay is active level width plus counter period.
// - Count done restarts clock and vectors to interrupt handler.
// - STOP command with an edge still unaccepted is not taken; execution continues.
// - Reset pin falling edge ends STOP.
// - Reset rising edge after wake branches to reset vector; clock already runs from the falling edge.
// - Resonator mode holds execution until the counter completes.
// - Select bit picks resonator divide by 2^8 or 2^9.
// - In STOP, CPU halts, state is held, peripherals stop.
// - Waking interrupt edge is also a normal interrupt request.
// - STOP entered from handler: wake only, request stays pending.
// - STOP refused with direct mode pin or external clock selected.
`timescale 1ns/1ps
module stop_wake_osc_stabilizer (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire        nmi_pin,
  input  wire        nmi_falling_valid,
  input  wire        reset_pin_n,
  input  wire        osc_tick,
  input  wire        sys_clk_in,
  input  wire        direct_mode_pin,
  input  wire        flash_prog_mode,
  input  wire        nmi_accept,
  input  wire        nmi_return,
  output wire        system_clock_output_pin,
  output wire        system_clock_output_oe,
  output wire        cpu_clock_enable,
  output wire        peripheral_clock_enable,
  output reg         nmi_request,
  output reg         reset_vector_req,
  output reg         nmi_vector_req,
  output wire        system_reset
);
`include "stop_wake_map.vh"

  // One-hot states; RUN is the only state with clocks running
  localparam [3:0] ST_RUN   = 4'b0001;
  localparam [3:0] ST_STOP  = 4'b0010;
  localparam [3:0] ST_WAIT  = 4'b0100;
  localparam [3:0] ST_COUNT = 4'b1000;

  // Synchroniser lanes: 0 interrupt, 1 reset, 2 direct mode, 3 flash mode
  localparam       SYNC_LANES = 4;
  localparam       LANE_NMI   = 0;
  localparam       LANE_RST   = 1;
  localparam       LANE_DIR   = 2;
  localparam       LANE_FLASH = 3;
  // Reset pin lane starts high so no false fall follows reset
  localparam [3:0] SYNC_INIT  = 4'b0010;

  reg  [3:0]            state_reg;
  reg  [3:0]            state_next;
  reg  [`PWR_WIDTH-1:0] power_save_control_reg;
  reg                   nmi_prev_reg;
  reg                   rst_prev_reg;
  reg  [2:0]            nmi_arm_reg;
  reg                   in_nmi_reg;
  reg                   rst_wake_reg;
  wire [SYNC_LANES-1:0] pin_raw;
  wire [SYNC_LANES-1:0] pin_sync;
  wire                  nmi_level;
  wire                  rst_level;
  wire                  dir_level;
  wire                  flash_level;
  wire                  clk_out_inhibit_bit_a;
  wire                  clk_out_inhibit_bit_b;
  wire                  stabilization_clock_select;
  wire                  external_clock_input_select;
  wire                  nmi_active;
  wire                  nmi_valid_edge;
  wire                  rst_fall;
  wire                  rst_rise;
  wire                  pwr_write;
  wire                  stop_req;
  wire                  stop_allowed;
  wire                  stab_start;
  wire                  stab_done;
  wire                  clocks_running;

  // Address decode shared by the write path, the STOP command and reads
  function hit_power_save;
    input [3:0] addr;
    begin
      hit_power_save = (addr == `ADDR_POWER_SAVE);
    end
  endfunction

  function hit_status;
    input [3:0] addr;
    begin
      hit_status = (addr == `ADDR_STATUS);
    end
  endfunction

  assign clk_out_inhibit_bit_a       = power_save_control_reg[`PWR_INH_A_BIT];
  assign clk_out_inhibit_bit_b       = power_save_control_reg[`PWR_INH_B_BIT];
  assign stabilization_clock_select  = power_save_control_reg[`PWR_STAB_SEL_BIT];
  // The selection written with the STOP command is the one in force
  assign external_clock_input_select = reg_wdata[`PWR_EXT_CLK_BIT];

  // Pin inputs come from outside the clock domain
  assign pin_raw = {flash_prog_mode, direct_mode_pin, reset_pin_n, nmi_pin};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_LANES; gi = gi + 1) begin : g_sync
      reg first_ff_reg;
      reg second_ff_reg;
      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          first_ff_reg  <= SYNC_INIT[gi];
          second_ff_reg <= SYNC_INIT[gi];
        end else begin
          first_ff_reg  <= pin_raw[gi];
          second_ff_reg <= first_ff_reg;
        end
      end
      // Only the second stage is read outside the lane
      assign pin_sync[gi] = second_ff_reg;
    end
  endgenerate

  assign nmi_level   = pin_sync[LANE_NMI];
  assign rst_level   = pin_sync[LANE_RST];
  assign dir_level   = pin_sync[LANE_DIR];
  assign flash_level = pin_sync[LANE_FLASH];

  // Interrupt edges wait until the history holds real pin samples,
  // whatever the selected polarity, so reset never fakes an edge
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nmi_prev_reg <= 1'b0;
      rst_prev_reg <= 1'b1;
      nmi_arm_reg  <= 3'h0;
    end else begin
      nmi_prev_reg <= nmi_active;
      rst_prev_reg <= rst_level;
      nmi_arm_reg  <= {nmi_arm_reg[1:0], 1'b1};
    end
  end

  // Active level follows the selected valid edge polarity
  assign nmi_active     = nmi_level ^ nmi_falling_valid;
  assign nmi_valid_edge = nmi_arm_reg[2] & nmi_active & ~nmi_prev_reg;
  assign rst_fall       = rst_prev_reg & ~rst_level;
  assign rst_rise       = ~rst_prev_reg & rst_level;

  // Reset pin low is passed on as system reset, same as a cold reset
  assign system_reset = ~rst_level;

  assign pwr_write    = reg_wr && hit_power_save(reg_addr);
  assign stop_req     = pwr_write && reg_wdata[`PWR_STOP_BIT];
  assign stop_allowed = ~dir_level & ~external_clock_input_select;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      power_save_control_reg <= `PWR_RESET;
    end else if (!rst_level) begin
      // Pin reset clears settings exactly as a cold reset does
      power_save_control_reg <= `PWR_RESET;
    end else if (pwr_write) begin
      // STOP is a command bit and is not held
      power_save_control_reg <= {1'b0, reg_wdata[3:0]};
    end
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        // A pending request blocks STOP entry so no edge is lost
        if (stop_req && stop_allowed && !nmi_request) begin
          state_next = ST_STOP;
        end
      end
      ST_STOP: begin
        if (rst_fall) begin
          state_next = ST_RUN;
        end else if (nmi_valid_edge) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!nmi_active) begin
          state_next = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (stab_done) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= ST_RUN;
    end else if (!rst_level) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Counter starts at the inactive edge, so the total wait is level width plus period
  assign stab_start = (state_reg == ST_WAIT) && !nmi_active;

  stabilization_time_counter u_stab (
    .clk_sys                    (clk_sys),
    .rst                        (rst),
    .start                      (stab_start),
    .osc_tick                   (osc_tick),
    .stabilization_clock_select (stabilization_clock_select),
    .done                       (stab_done)
  );

  // Execution held in STOP and during stabilization
  assign clocks_running          = (state_reg == ST_RUN);
  assign cpu_clock_enable        = clocks_running;
  assign peripheral_clock_enable = clocks_running;

  // Request set wins over accept in the same cycle; a pin reset
  // drops request and handler state as a cold reset would
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nmi_request      <= 1'b0;
      in_nmi_reg       <= 1'b0;
      rst_wake_reg     <= 1'b0;
      reset_vector_req <= 1'b0;
      nmi_vector_req   <= 1'b0;
    end else begin
      reset_vector_req <= 1'b0;
      nmi_vector_req   <= 1'b0;
      if (!rst_level) begin
        nmi_request <= 1'b0;
      end else if (nmi_valid_edge) begin
        nmi_request <= 1'b1;
      end else if (nmi_accept && state_reg == ST_RUN) begin
        nmi_request <= 1'b0;
      end
      if (!rst_level) begin
        in_nmi_reg <= 1'b0;
      end else if (nmi_accept) begin
        in_nmi_reg <= 1'b1;
      end else if (nmi_return) begin
        in_nmi_reg <= 1'b0;
      end
      // Wake marker survives the pin reset it was made by
      if (state_reg == ST_STOP && rst_fall) begin
        rst_wake_reg <= 1'b1;
      end else if (rst_wake_reg && rst_rise) begin
        rst_wake_reg     <= 1'b0;
        reset_vector_req <= 1'b1;
      end
      // Inside the handler the wake only ends STOP; request stays pending
      if (state_reg == ST_COUNT && stab_done && !in_nmi_reg) begin
        nmi_vector_req <= 1'b1;
      end
    end
  end

  // Limitation: the flash mode level is seen two clocks late on the pin
  assign system_clock_output_oe = ~flash_level &
                                  ~(clk_out_inhibit_bit_a & clk_out_inhibit_bit_b);
  // Low level while the internal clock is stopped
  assign system_clock_output_pin = system_clock_output_oe & sys_clk_in &
                                   clocks_running;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (hit_power_save(reg_addr)) begin
        reg_rdata <= {3'h0, power_save_control_reg};
      end else if (hit_status(reg_addr)) begin
        reg_rdata <= {3'h0, in_nmi_reg, nmi_request, state_reg[3], state_reg[2],
                      state_reg[1]};
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // stop_wake_osc_stabilizer

//--- test/stop_wake_osc_stabilizer_properties.sv
// Port-level checks for the STOP wake-up block
`timescale 1ns/1ps
`include "stop_wake_map.vh"
module stop_wake_props (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       direct_mode_pin,
  input wire logic       flash_prog_mode,
  input wire logic       reset_pin_n,
  input wire logic       system_clock_output_pin,
  input wire logic       system_clock_output_oe,
  input wire logic       cpu_clock_enable,
  input wire logic       peripheral_clock_enable,
  input wire logic       nmi_request,
  input wire logic       nmi_vector_req,
  input wire logic       reset_vector_req,
  input wire logic       system_reset
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence stop_cmd;
    reg_wr && reg_addr == `ADDR_POWER_SAVE && reg_wdata[`PWR_STOP_BIT];
  endsequence
  // Pins pass a two-stage synchroniser, so three quiet samples are needed
  sequence stop_ok;
    !direct_mode_pin[*3] ##0 stop_cmd ##0 (!reg_wdata[`PWR_EXT_CLK_BIT] && !nmi_request
      && !system_reset && cpu_clock_enable);
  endsequence
  chk_clk_inhibit: assert property (
    reg_wr && reg_addr == `ADDR_POWER_SAVE && reg_wdata[1:0] == 2'b11 && !system_reset
    |=> !system_clock_output_oe)
    else $error("clock pin driven while inhibited");
  chk_flash_undriven: assert property (
    flash_prog_mode[*4] |-> !system_clock_output_oe) else $error("clock pin driven in flash mode");
  chk_stop_enter: assert property (stop_ok |=> !cpu_clock_enable)
    else $error("stop command not taken");
  chk_refuse_direct: assert property (
    direct_mode_pin[*3] ##0 stop_cmd ##0 cpu_clock_enable |=> cpu_clock_enable)
    else $error("stop taken in direct mode");
  chk_pin_low_stop: assert property (!cpu_clock_enable |-> !system_clock_output_pin)
    else $error("clock pin not low while stopped");
  chk_periph_same: assert property (cpu_clock_enable == peripheral_clock_enable)
    else $error("peripheral clock differs from cpu clock");
  chk_nmi_vec_once: assert property (nmi_vector_req |=> !nmi_vector_req)
    else $error("nmi vector pulse too long");
  chk_nmi_vec_run: assert property (nmi_vector_req |-> ##[0:1] cpu_clock_enable)
    else $error("clock not restarted with nmi vector");
  chk_reset_wake: assert property (
    !reset_pin_n[*4] |-> system_reset && cpu_clock_enable) else $error("reset pin did not wake");
  chk_reset_vec: assert property (
    reset_vector_req |-> !system_reset ##1 !reset_vector_req) else $error("bad reset vector");
endmodule // stop_wake_props
bind stop_wake_osc_stabilizer stop_wake_props u_props (.clk_sys(clk_sys), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .direct_mode_pin(direct_mode_pin), .flash_prog_mode(flash_prog_mode),
  .reset_pin_n(reset_pin_n), .system_clock_output_pin(system_clock_output_pin),
  .system_clock_output_oe(system_clock_output_oe), .cpu_clock_enable(cpu_clock_enable),
  .peripheral_clock_enable(peripheral_clock_enable), .nmi_request(nmi_request),
  .nmi_vector_req(nmi_vector_req), .reset_vector_req(reset_vector_req),
  .system_reset(system_reset));

//--- test/tb.sv
// Self-checking bench for the STOP wake-up block
`timescale 1ns/1ps
`include "stop_wake_map.vh"
module tb;
  logic       clk_sys, rst, reg_wr, reg_rd, nmi_hold, reset_hold, slow;
  logic       direct_mode_pin, flash_prog_mode, nmi_accept, nmi_return;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, got;
  wire  [7:0] reg_rdata;
  wire        nmi_pin, reset_pin_n, osc_tick, clk_pin, clk_oe, cpu_en, per_en;
  wire        nmi_request, reset_vector_req, nmi_vector_req, system_reset;
  int         fails, checks_done, cyc, lo;
  wake_sources u_src (.clk_sys(clk_sys), .nmi_hold(nmi_hold), .reset_hold(reset_hold),
    .slow(slow), .nmi_pin(nmi_pin), .reset_pin_n(reset_pin_n), .osc_tick(osc_tick));
  stop_wake_osc_stabilizer DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .nmi_pin(nmi_pin), .nmi_falling_valid(1'b1), .reset_pin_n(reset_pin_n),
    .osc_tick(osc_tick), .sys_clk_in(clk_sys), .direct_mode_pin(direct_mode_pin),
    .flash_prog_mode(flash_prog_mode), .nmi_accept(nmi_accept), .nmi_return(nmi_return),
    .system_clock_output_pin(clk_pin), .system_clock_output_oe(clk_oe),
    .cpu_clock_enable(cpu_en), .peripheral_clock_enable(per_en),
    .nmi_request(nmi_request), .reset_vector_req(reset_vector_req),
    .nmi_vector_req(nmi_vector_req), .system_reset(system_reset));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = !clk_sys;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string what);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e, "read data");
    @(posedge clk_sys);
  endtask
  task automatic pulse(input bit ret);
    if (ret) nmi_return <= 1'b1;
    else nmi_accept <= 1'b1;
    @(posedge clk_sys);
    nmi_accept <= 1'b0;
    nmi_return <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Counts edges until the chosen vector pulse; a missed pulse ends the run when must is set
  task automatic wait_vec(input bit nmi_kind, input int lim, input bit must);
    cyc = 0;
    do begin
      @(posedge clk_sys);
      #1;
      cyc++;
    end while ((nmi_kind ? nmi_vector_req : reset_vector_req) !== 1'b1 && cyc < lim);
    if (must && cyc >= lim) begin
      fails++;
      $display("CHECK FAILED at %0t: vector pulse timed out", $time);
      report_and_stop();
    end
    @(posedge clk_sys);
  endtask
  initial begin
    {rst, reg_wr, reg_rd, nmi_hold, reset_hold, slow, direct_mode_pin} = 7'h7f & 7'h40;
    {flash_prog_mode, nmi_accept, nmi_return, reg_addr, reg_wdata} = 15'h0000;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(`ADDR_POWER_SAVE, `PWR_RESET);
    rd(4'hf, 8'h00);
    chk(clk_oe, 1'b1, "oe after reset");
    #1;
    chk(clk_pin, 1'b1, "clock pin runs");
    wr(`ADDR_POWER_SAVE, 8'h03);
    chk(clk_oe, 1'b0, "oe inhibited");
    wr(`ADDR_POWER_SAVE, 8'h01);
    chk(clk_oe, 1'b1, "oe one bit");
    flash_prog_mode <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk(clk_oe, 1'b0, "oe in flash mode");
    flash_prog_mode <= 1'b0;
    direct_mode_pin <= 1'b1;
    repeat (5) @(posedge clk_sys);
    wr(`ADDR_POWER_SAVE, 8'h10);
    chk(cpu_en, 1'b1, "stop in direct mode");
    direct_mode_pin <= 1'b0;
    repeat (5) @(posedge clk_sys);
    wr(`ADDR_POWER_SAVE, 8'h18);
    chk(cpu_en, 1'b1, "stop with external clock");
    $display("test clock output and refusals done");
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      wr(`ADDR_POWER_SAVE, k ? 8'h14 : 8'h10);
      chk(cpu_en, 1'b0, "stop entered");
      chk(clk_pin, 1'b0, "clock pin low in stop");
      nmi_hold <= 1'b1;
      repeat (40) @(posedge clk_sys);
      chk(cpu_en, 1'b0, "held while pin active");
      nmi_hold <= 1'b0;
      wait_vec(1'b1, 3000, 1'b1);
      lo = k ? 2 << `STAB_EXP_SEL1 : 1 << `STAB_EXP_SEL0;
      chk(8'(cyc >= lo && cyc <= lo + 8), 8'h01, "stabilization count");
      chk(cpu_en, 1'b1, "clock restarted");
      chk(per_en, 1'b1, "peripherals restarted");
      chk(nmi_request, 1'b1, "wake edge is a request");
      pulse(1'b0);
      pulse(1'b1);
    end
    slow <= 1'b0;
    $display("test nmi wake done");
    nmi_hold <= 1'b1;
    repeat (4) @(posedge clk_sys);
    nmi_hold <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wr(`ADDR_POWER_SAVE, 8'h10);
    chk(cpu_en, 1'b1, "prompt exit with pending edge");
    pulse(1'b0);
    wr(`ADDR_POWER_SAVE, 8'h10);
    nmi_hold <= 1'b1;
    repeat (4) @(posedge clk_sys);
    nmi_hold <= 1'b0;
    wait_vec(1'b1, 400, 1'b0);
    chk(8'(cyc), 8'(400), "no vector inside handler");
    chk({nmi_request, cpu_en}, 2'b11, "pending after handler wake");
    pulse(1'b0);
    pulse(1'b1);
    $display("test pending and handler wake done");
    wr(`ADDR_POWER_SAVE, 8'h13);
    rd(`ADDR_STATUS, 8'h01);
    reset_hold <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk({system_reset, cpu_en}, 2'b11, "reset pin wake");
    reset_hold <= 1'b0;
    wait_vec(1'b0, 20, 1'b1);
    chk(clk_oe, 1'b1, "inhibit cleared by reset");
    rd(`ADDR_POWER_SAVE, `PWR_RESET);
    $display("test reset wake done");
    report_and_stop();
  end
endmodule // tb

//--- test/wake_sources.sv
// Model of the interrupt and reset pin sources and the resonator tick
`timescale 1ns/1ps
module wake_sources (
  input  wire logic clk_sys,
  input  wire logic nmi_hold,
  input  wire logic reset_hold,
  input  wire logic slow,
  output wire logic nmi_pin,
  output wire logic reset_pin_n,
  output wire logic osc_tick
);
  logic phase = 1'b0;
  // Idle high: falling edge is the valid one
  assign nmi_pin     = !nmi_hold;
  assign reset_pin_n = !reset_hold;
  // Slow resonator ticks every other cycle
  assign osc_tick    = !slow || phase;
  always @(posedge clk_sys) begin
    phase <= !phase;
  end
endmodule // wake_sources
